// ===== logic/fuse_regs.svh
// offsets, field positions, reset values and timing counts of the fuse decoder
`ifndef FUSE_REGS_SVH
`define FUSE_REGS_SVH
// clock timing
`define CLK_PERIOD_NS 5
`define US_NS 1000
`define TICK_CYCLES (`US_NS / `CLK_PERIOD_NS)
`define WDT_BASE_MS 20
`define WDT_BASE_CYCLES (`WDT_BASE_MS * 1000000 / `CLK_PERIOD_NS)
// configuration block placement, word index inside the block
`define CFG_BASE 32'h0001_0000
`define CFG_WORDS 64
`define IDX_CLK 6'h00
`define IDX_SYS 6'h01
`define IDX_TRIM 6'h04
`define WORD_ERASED 16'hffff
// clock word fields
`define MAIN_OFF_BIT 15
`define RT_OFF_BIT 14
`define POST_HI 13
`define POST_LO 12
`define PRE_HI 11
`define PRE_LO 9
`define PLL_WAKE_HI 5
`define PLL_WAKE_LO 3
`define OSC_WAKE_HI 2
`define OSC_WAKE_LO 0
// system word fields
`define PROTECT_N_BIT 15
`define SYNC_BYPASS_BIT 14
`define DROP_HI 6
`define DROP_LO 4
`define DROP_OFF_CODE 3'h7
`define WDT_ON_BIT 3
`define WDT_PS_HI 2
`define WDT_PS_LO 0
// trim word fields
`define VCO_HI 15
`define VCO_LO 12
`define SQ3_BIT 11
`define ERASE_SHORT_BIT 10
`define CMP_HI 9
`define CMP_LO 7
`define SQ4_BIT 6
`define DROPT_HI 5
`define DROPT_LO 3
`define SQ_LO_HI 2
// suspend times after PLL start, microseconds
`define PLL_WAKE0_US 128
`define PLL_WAKE1_US 192
`define PLL_WAKE2_US 320
`define PLL_WAKE3_US 576
`define PLL_WAKE4_US 1088
`define PLL_WAKE5_US 2112
`define PLL_WAKE6_US 4160
`define PLL_WAKE7_US 8256
// suspend times after oscillator start, microseconds
`define OSC_WAKE0_US 320
`define OSC_WAKE1_US 1088
`define OSC_WAKE2_US 4160
`define OSC_WAKE3_US 8256
`define OSC_WAKE4_US 16448
`define OSC_WAKE5_US 65600
`define OSC_WAKE6_US 524352
`define OSC_WAKE7_US 1048640
// flash block erase pulse, microseconds
`define ERASE_LONG_US 20000
`define ERASE_SHORT_US 10000
`define PORT_WIDTH 8
`endif

// ===== logic/fuse_pkg.sv
// types shared by the fuse decoder and its watchdog
`include "fuse_regs.svh"
`default_nettype none
package fuse_pkg;
    typedef enum logic [1:0] {
        SUSP_IDLE = 2'b00,
        SUSP_PLL = 2'b01,
        SUSP_OSC = 2'b10
    } suspend_t;
    typedef struct packed {
        logic [`CFG_WORDS-1:0][15:0] cfg;
        logic [15:0] clk_word;
        logic [15:0] sys_word;
        logic [15:0] trim_word;
        logic load;
        logic [`PORT_WIDTH-1:0] port_stage;
        logic pll_off_d;
        suspend_t susp;
        logic [20:0] susp_us;
        logic [15:0] tick_cnt;
        logic [14:0] erase_us;
        logic [15:0] rd_data;
        logic rd_valid;
    } core_state_t;
    typedef struct packed {
        logic [31:0] base_cnt;
        logic [7:0] pre_cnt;
        logic expire;
    } wd_state_t;
endpackage
`default_nettype wire

// ===== logic/watchdog_timer.sv
// watchdog counter with power-of-two prescaler
`include "fuse_regs.svh"
`default_nettype none
module watchdog_timer
    import fuse_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = `WDT_BASE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic enable,
    input wire logic [2:0] prescale,
    input wire logic clear,
    // expiry
    output logic expire
);
    wd_state_t state_ff;
    wd_state_t nxt_state;
    logic base_wrap;
    logic [7:0] pre_last;

    assign base_wrap = (state_ff.base_cnt == 32'(BASE_CYCLES - 1));
    assign pre_last = (8'h01 << prescale) - 8'h01;
    assign expire = state_ff.expire;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.expire = 1'b0;
        if (!rst_n || clear || !enable) begin
            nxt_state.base_cnt = '0;
            nxt_state.pre_cnt = '0;
        end else if (base_wrap) begin
            nxt_state.base_cnt = '0;
            if (state_ff.pre_cnt >= pre_last) begin
                nxt_state.pre_cnt = '0;
                nxt_state.expire = 1'b1;
            end else begin
                nxt_state.pre_cnt = state_ff.pre_cnt + 8'h01;
            end
        end else begin
            nxt_state.base_cnt = state_ff.base_cnt + 32'h1;
        end
        if (!rst_n) begin
            nxt_state.expire = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        state_ff <= nxt_state;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wdt_clear_a: assert property (clear |=> state_ff.base_cnt == 0 && state_ff.pre_cnt == 0)
        else $error("watchdog not cleared");
    wdt_enable_a: assert property (expire |-> $past(enable) && !$past(clear))
        else $error("watchdog expired while off or cleared");
    wdt_prescale_a: assert property (expire |-> $past(state_ff.pre_cnt) == $past(pre_last))
        else $error("watchdog expired at wrong prescale count");
endmodule // watchdog_timer
`default_nettype wire

// ===== logic/fuse_config_decoder.sv
// configuration fuse words and their static decode
//
// What this block does
// - clock word bit 15 high: main drive off
// - clock word bit 14 high: rt drive off
// - post divider ratio is code plus one
// - pre divider bits 11:9, ratio code plus one
// - PLL start suspends clock per table
// - oscillator start suspends clock per table
// - protect bit cleared stays cleared until erase or power-on reset
// - protected: programmer program reads return zero
// - protected: debug access refused
// - configuration words always readable by programmer
// - bypass bit selects direct or registered pins
// - drop code picks brown-out reset threshold
// - drop code 111 never gives brown-out reset
// - watchdog divisor is two to the code
// - clear or reset pin clears watchdog fully
// - erase pulse 20 ms, or 10 ms
// - trim fields passed out unchanged
// - only three words drive any hardware
`include "fuse_regs.svh"
`default_nettype none
module fuse_config_decoder
    import fuse_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
    parameter int unsigned WDT_BASE_CYCLES = `WDT_BASE_CYCLES
) (
    // clock and resets
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic POR_N,
    // programmer port
    input wire logic [31:0] PGM_ADDR,
    input wire logic PGM_WR,
    input wire logic [15:0] PGM_WDATA,
    input wire logic PGM_RD,
    input wire logic PGM_ERASE,
    input wire logic [15:0] FLASH_RD_DATA,
    output logic [15:0] PGM_RDATA,
    output logic PGM_RVALID,
    output logic DBG_ALLOW,
    output logic PROTECT_ON,
    // clock control
    output logic MAIN_OSC_DRIVE_OFF,
    output logic RT_OSC_DRIVE_OFF,
    output logic [2:0] POST_DIV_RATIO,
    output logic [3:0] PRE_DIV_RATIO,
    input wire logic SPD_PLL_OFF,
    input wire logic OSC_START,
    output logic CLK_SUSPEND,
    // port input path
    input wire logic [`PORT_WIDTH-1:0] PORT_PINS,
    output logic [`PORT_WIDTH-1:0] PORT_IN_VALUE,
    // supply monitor
    input wire logic SUPPLY_LOW,
    output logic [2:0] SUPPLY_DROP_LEVEL,
    output logic SUPPLY_DROP_EN,
    output logic BROWNOUT_RESET,
    // watchdog
    input wire logic WDT_CLEAR,
    output logic WDT_RESET,
    // flash erase
    input wire logic ERASE_START,
    output logic ERASE_BUSY,
    // analog trims
    output logic [5:0] SQUELCH_TRIM,
    output logic [2:0] COMPARATOR_TRIM,
    output logic [3:0] OSCILLATOR_TRIM,
    output logic [2:0] SUPPLY_DROP_TRIM
);
    localparam logic [31:0] CFG_BASE = `CFG_BASE;

    core_state_t state_ff;
    core_state_t nxt_state;
    logic [15:0] cw;
    logic [15:0] sw;
    logic [15:0] tw;
    logic [5:0] idx;
    logic cfg_hit;
    logic tick;
    logic pll_start;

    ////////////////////////////////////////////////////////////////////////////
    // lookup of suspend times
    function automatic logic [20:0] pll_wake_us(input logic [2:0] code);
        case (code)
            3'h0: pll_wake_us = 21'(`PLL_WAKE0_US);
            3'h1: pll_wake_us = 21'(`PLL_WAKE1_US);
            3'h2: pll_wake_us = 21'(`PLL_WAKE2_US);
            3'h3: pll_wake_us = 21'(`PLL_WAKE3_US);
            3'h4: pll_wake_us = 21'(`PLL_WAKE4_US);
            3'h5: pll_wake_us = 21'(`PLL_WAKE5_US);
            3'h6: pll_wake_us = 21'(`PLL_WAKE6_US);
            default: pll_wake_us = 21'(`PLL_WAKE7_US);
        endcase
    endfunction

    function automatic logic [20:0] osc_wake_us(input logic [2:0] code);
        case (code)
            3'h0: osc_wake_us = 21'(`OSC_WAKE0_US);
            3'h1: osc_wake_us = 21'(`OSC_WAKE1_US);
            3'h2: osc_wake_us = 21'(`OSC_WAKE2_US);
            3'h3: osc_wake_us = 21'(`OSC_WAKE3_US);
            3'h4: osc_wake_us = 21'(`OSC_WAKE4_US);
            3'h5: osc_wake_us = 21'(`OSC_WAKE5_US);
            3'h6: osc_wake_us = 21'(`OSC_WAKE6_US);
            default: osc_wake_us = 21'(`OSC_WAKE7_US);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // static decode from the captured copies
    assign cw = state_ff.clk_word;
    assign sw = state_ff.sys_word;
    assign tw = state_ff.trim_word;
    assign idx = PGM_ADDR[5:0];
    assign cfg_hit = (PGM_ADDR[31:6] == CFG_BASE[31:6]);
    assign tick = (state_ff.tick_cnt == 16'(TICK_CYCLES - 1));
    assign pll_start = state_ff.pll_off_d & ~SPD_PLL_OFF;

    assign MAIN_OSC_DRIVE_OFF = cw[`MAIN_OFF_BIT];
    assign RT_OSC_DRIVE_OFF = cw[`RT_OFF_BIT];
    assign POST_DIV_RATIO = {1'b0, cw[`POST_HI:`POST_LO]} + 3'h1;
    assign PRE_DIV_RATIO = {1'b0, cw[`PRE_HI:`PRE_LO]} + 4'h1;
    assign CLK_SUSPEND = (state_ff.susp != SUSP_IDLE);

    // protection follows the stored bit at once, or the captured copy
    assign PROTECT_ON = ~sw[`PROTECT_N_BIT] | ~state_ff.cfg[`IDX_SYS][`PROTECT_N_BIT];
    assign DBG_ALLOW = ~PROTECT_ON;
    assign PGM_RDATA = state_ff.rd_data;
    assign PGM_RVALID = state_ff.rd_valid;

    assign PORT_IN_VALUE = sw[`SYNC_BYPASS_BIT] ? PORT_PINS : state_ff.port_stage;

    assign SUPPLY_DROP_LEVEL = sw[`DROP_HI:`DROP_LO];
    assign SUPPLY_DROP_EN = (SUPPLY_DROP_LEVEL != `DROP_OFF_CODE);
    assign BROWNOUT_RESET = SUPPLY_LOW & SUPPLY_DROP_EN;

    assign ERASE_BUSY = (state_ff.erase_us != 15'h0);

    // reserved bits of the words reach no decoded output, only PGM_RDATA on a configuration read
    assign SQUELCH_TRIM = {1'b0, tw[`SQ4_BIT], tw[`SQ3_BIT], tw[`SQ_LO_HI:0]};
    assign COMPARATOR_TRIM = tw[`CMP_HI:`CMP_LO];
    assign OSCILLATOR_TRIM = tw[`VCO_HI:`VCO_LO];
    assign SUPPLY_DROP_TRIM = tw[`DROPT_HI:`DROPT_LO];

    ////////////////////////////////////////////////////////////////////////////
    // watchdog
    watchdog_timer #(
        .BASE_CYCLES(WDT_BASE_CYCLES)
    ) u_wdt (
        .clk(CLK),
        .rst_n(RST_N),
        .enable(sw[`WDT_ON_BIT]),
        .prescale(sw[`WDT_PS_HI:`WDT_PS_LO]),
        .clear(WDT_CLEAR),
        .expire(WDT_RESET)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rd_valid = 1'b0;
        nxt_state.tick_cnt = tick ? 16'h0 : state_ff.tick_cnt + 16'h1;
        nxt_state.port_stage = PORT_PINS;
        nxt_state.pll_off_d = SPD_PLL_OFF;
        // capture once, first cycle after reset release
        if (state_ff.load) begin
            nxt_state.load = 1'b0;
            nxt_state.clk_word = state_ff.cfg[`IDX_CLK];
            nxt_state.sys_word = state_ff.cfg[`IDX_SYS];
            nxt_state.trim_word = state_ff.cfg[`IDX_TRIM];
        end
        // programmer writes keep every bit, reserved ones too, except that a cleared protect bit stays cleared
        if (PGM_WR && cfg_hit) begin
            nxt_state.cfg[idx] = PGM_WDATA;
            if (idx == `IDX_SYS) begin
                nxt_state.cfg[idx][`PROTECT_N_BIT] =
                    PGM_WDATA[`PROTECT_N_BIT] & state_ff.cfg[idx][`PROTECT_N_BIT];
            end
        end
        if (PGM_ERASE && PGM_ADDR == CFG_BASE) begin
            nxt_state.cfg = {`CFG_WORDS{`WORD_ERASED}};
        end
        if (PGM_RD) begin
            nxt_state.rd_valid = 1'b1;
            if (cfg_hit) begin
                nxt_state.rd_data = state_ff.cfg[idx];
            end else if (PROTECT_ON) begin
                nxt_state.rd_data = 16'h0;
            end else begin
                nxt_state.rd_data = FLASH_RD_DATA;
            end
        end
        // clock suspend; one extra microsecond covers the partial first tick
        case (state_ff.susp)
            SUSP_IDLE: begin
                nxt_state.susp_us = 21'h0;
            end
            SUSP_PLL, SUSP_OSC: begin
                if (tick) begin
                    if (state_ff.susp_us <= 21'h1) begin
                        nxt_state.susp = SUSP_IDLE;
                        nxt_state.susp_us = 21'h0;
                    end else begin
                        nxt_state.susp_us = state_ff.susp_us - 21'h1;
                    end
                end
            end
            default: begin
                nxt_state.susp = SUSP_IDLE;
                nxt_state.susp_us = 21'h0;
            end
        endcase
        if (OSC_START) begin
            nxt_state.susp = SUSP_OSC;
            nxt_state.susp_us = osc_wake_us(cw[`OSC_WAKE_HI:`OSC_WAKE_LO]) + 21'h1;
        end else if (pll_start) begin
            nxt_state.susp = SUSP_PLL;
            nxt_state.susp_us = pll_wake_us(cw[`PLL_WAKE_HI:`PLL_WAKE_LO]) + 21'h1;
        end
        // flash erase pulse
        if (ERASE_START && !ERASE_BUSY) begin
            nxt_state.erase_us = tw[`ERASE_SHORT_BIT] ? 15'(`ERASE_SHORT_US + 1) : 15'(`ERASE_LONG_US + 1);
        end else if (ERASE_BUSY && tick) begin
            nxt_state.erase_us = state_ff.erase_us - 15'h1;
        end
        if (!RST_N) begin
            nxt_state.clk_word = `WORD_ERASED;
            nxt_state.sys_word = `WORD_ERASED;
            nxt_state.trim_word = `WORD_ERASED;
            nxt_state.load = 1'b1;
            nxt_state.port_stage = '0;
            nxt_state.pll_off_d = 1'b1;
            nxt_state.susp = SUSP_IDLE;
            nxt_state.susp_us = 21'h0;
            nxt_state.tick_cnt = 16'h0;
            nxt_state.erase_us = 15'h0;
            nxt_state.rd_data = 16'h0;
            nxt_state.rd_valid = 1'b0;
        end
        if (!POR_N) begin
            nxt_state.cfg = {`CFG_WORDS{`WORD_ERASED}};
        end
    end

    always_ff @(posedge CLK) begin
        state_ff <= nxt_state;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N || !POR_N);

    sequence pll_clear_s;
        $fell(SPD_PLL_OFF) && !OSC_START;
    endsequence
    sequence held_suspend_s;
        CLK_SUSPEND [*8];
    endsequence

    main_drive_a: assert property (state_ff.load |=> MAIN_OSC_DRIVE_OFF == $past(state_ff.cfg[0][15]))
        else $error("main drive does not follow captured word");
    rt_drive_a: assert property (state_ff.load |=> RT_OSC_DRIVE_OFF == $past(state_ff.cfg[0][14]))
        else $error("rt drive does not follow captured word");
    post_div_a: assert property (POST_DIV_RATIO == {1'b0, state_ff.clk_word[13:12]} + 3'h1)
        else $error("post divider ratio wrong");
    pre_div_a: assert property (PRE_DIV_RATIO == {1'b0, state_ff.clk_word[11:9]} + 4'h1)
        else $error("pre divider ratio wrong");
    pll_suspend_a: assert property (pll_clear_s |=> held_suspend_s)
        else $error("clock not suspended after PLL start");
    osc_suspend_a: assert property (OSC_START |=> held_suspend_s)
        else $error("clock not suspended after oscillator start");
    protect_sticky_a: assert property (!state_ff.cfg[1][15] && !PGM_ERASE |=> !state_ff.cfg[1][15])
        else $error("protect bit set back without erase");
    read_zero_a: assert property (PGM_RD && !cfg_hit && PROTECT_ON |=> PGM_RVALID && PGM_RDATA == 16'h0)
        else $error("protected program read not zero");
    debug_block_a: assert property (!state_ff.cfg[1][15] |-> !DBG_ALLOW)
        else $error("debug allowed while protected");
    cfg_read_a: assert property (PGM_RD && cfg_hit |=> PGM_RDATA == $past(state_ff.cfg[idx]))
        else $error("configuration read blocked or wrong");
    port_sync_a: assert property (!sw[14] && !state_ff.load |=> $past(sw[14]) || PORT_IN_VALUE == $past(PORT_PINS))
        else $error("port path not registered");
    drop_off_a: assert property (SUPPLY_DROP_LEVEL == 3'h7 |-> !BROWNOUT_RESET)
        else $error("brown-out reset while disabled");
    erase_pulse_a: assert property ($rose(ERASE_BUSY) |-> ERASE_BUSY [*8])
        else $error("erase pulse ended early");
    erase_start_a: assert property (ERASE_START && !ERASE_BUSY |=> ERASE_BUSY)
        else $error("erase pulse not started");
    rvalid_pulse_a: assert property (PGM_RVALID |-> $past(PGM_RD))
        else $error("read answer without request");
    copy_static_a: assert property (!state_ff.load |=> $stable(cw) && $stable(sw) && $stable(tw))
        else $error("captured words changed without reset");
    brownout_a: assert property (SUPPLY_LOW && SUPPLY_DROP_LEVEL != 3'h7 |-> BROWNOUT_RESET)
        else $error("brown-out reset missing");
endmodule // fuse_config_decoder
`default_nettype wire

// ===== sim/prog_model.sv
// device programmer model driving the programming port
`default_nettype none
module prog_model (
    // clock
    input wire logic clk,
    // programming port
    output logic [31:0] pgm_addr,
    output logic pgm_wr,
    output logic [15:0] pgm_wdata,
    output logic pgm_rd,
    output logic pgm_erase,
    output logic [15:0] flash_rd_data,
    input wire logic [15:0] pgm_rdata,
    input wire logic pgm_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pgm_addr = 32'h0000_0000;
        pgm_wr = 1'b0;
        pgm_wdata = 16'h0000;
        pgm_rd = 1'b0;
        pgm_erase = 1'b0;
    end
    // program memory contents seen at the pointer
    assign flash_rd_data = pgm_addr[15:0] ^ 16'h5a3c;
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(negedge clk);
        pgm_addr = a;
        pgm_wdata = d;
        pgm_wr = 1'b1;
        @(negedge clk);
        pgm_wr = 1'b0;
        pgm_wdata = ~d;
    endtask
    task automatic rd(input logic [31:0] a, output logic [15:0] d, output logic v);
        @(negedge clk);
        pgm_addr = a;
        pgm_rd = 1'b1;
        @(negedge clk);
        pgm_rd = 1'b0;
        d = pgm_rdata;
        v = pgm_rvalid;
    endtask
    task automatic bulk(input logic [31:0] a);
        @(negedge clk);
        pgm_addr = a;
        pgm_erase = 1'b1;
        @(negedge clk);
        pgm_erase = 1'b0;
    endtask
    // two bulk erases at zero, then the configuration block
    task automatic protected_erase();
        bulk(32'h0000_0000);
        bulk(32'h0000_0000);
        bulk(32'h0001_0000);
    endtask
endmodule // prog_model
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the fuse decoder
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 1;
    localparam int WDB = 8;
    localparam int LIMIT = 100000;
    localparam logic [31:0] CFG = 32'h0001_0000;
    logic clk, rst_n, por_n, spd_pll_off, osc_start, supply_low, wdt_clear, erase_start, rv;
    logic pgm_wr, pgm_rd, pgm_erase, pgm_rvalid, dbg_allow, protect_on, main_off, rt_off, clk_suspend;
    logic supply_drop_en, brownout_reset, wdt_reset, erase_busy;
    logic [31:0] pgm_addr, seed, x;
    logic [15:0] pgm_wdata, flash_rd_data, pgm_rdata, rdat, c, s, t, r;
    logic [7:0] port_pins, port_in_value, p1;
    logic [2:0] post_div, supply_drop_level, comparator_trim, supply_drop_trim;
    logic [3:0] pre_div, oscillator_trim;
    logic [5:0] squelch_trim;
    int mismatches = 0;
    int n_tests = 0;
    int wd_cnt = 0;
    int cycles = 0;
    int n;
    int pll_us[8] = '{128, 192, 320, 576, 1088, 2112, 4160, 8256};
    int osc_us[4] = '{320, 1088, 4160, 8256};
    fuse_config_decoder #(.TICK_CYCLES(TICK), .WDT_BASE_CYCLES(WDB)) u_fuse_config_decoder (
        .CLK(clk), .RST_N(rst_n), .POR_N(por_n), .PGM_ADDR(pgm_addr), .PGM_WR(pgm_wr), .PGM_WDATA(pgm_wdata),
        .PGM_RD(pgm_rd), .PGM_ERASE(pgm_erase), .FLASH_RD_DATA(flash_rd_data), .PGM_RDATA(pgm_rdata),
        .PGM_RVALID(pgm_rvalid), .DBG_ALLOW(dbg_allow), .PROTECT_ON(protect_on), .MAIN_OSC_DRIVE_OFF(main_off),
        .RT_OSC_DRIVE_OFF(rt_off), .POST_DIV_RATIO(post_div), .PRE_DIV_RATIO(pre_div),
        .SPD_PLL_OFF(spd_pll_off), .OSC_START(osc_start), .CLK_SUSPEND(clk_suspend), .PORT_PINS(port_pins),
        .PORT_IN_VALUE(port_in_value), .SUPPLY_LOW(supply_low), .SUPPLY_DROP_LEVEL(supply_drop_level),
        .SUPPLY_DROP_EN(supply_drop_en), .BROWNOUT_RESET(brownout_reset), .WDT_CLEAR(wdt_clear),
        .WDT_RESET(wdt_reset), .ERASE_START(erase_start), .ERASE_BUSY(erase_busy), .SQUELCH_TRIM(squelch_trim),
        .COMPARATOR_TRIM(comparator_trim), .OSCILLATOR_TRIM(oscillator_trim), .SUPPLY_DROP_TRIM(supply_drop_trim)
    );
    prog_model u_prog_model (
        .clk(clk), .pgm_addr(pgm_addr), .pgm_wr(pgm_wr), .pgm_wdata(pgm_wdata), .pgm_rd(pgm_rd),
        .pgm_erase(pgm_erase), .flash_rd_data(flash_rd_data), .pgm_rdata(pgm_rdata), .pgm_rvalid(pgm_rvalid)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (wdt_reset === 1'b1)
            wd_cnt++;
        if (cycles == LIMIT) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reset_core();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
    endtask
    task automatic load(input logic [15:0] cw, input logic [15:0] sw, input logic [15:0] tw);
        u_prog_model.wr(CFG, cw);
        u_prog_model.wr(CFG + 32'h1, sw);
        u_prog_model.wr(CFG + 32'h4, tw);
        reset_core();
    endtask
    task automatic check_decode(input logic [15:0] cw, input logic [15:0] sw, input logic [15:0] tw);
        chk(main_off, cw[15]);
        chk(rt_off, cw[14]);
        chk(post_div, {1'b0, cw[13:12]} + 3'h1);
        chk(pre_div, {1'b0, cw[11:9]} + 4'h1);
        chk(supply_drop_level, sw[6:4]);
        chk(supply_drop_en, sw[6:4] != 3'h7);
        chk(oscillator_trim, tw[15:12]);
        chk(squelch_trim, {1'b0, tw[6], tw[11], tw[2:0]});
        chk(comparator_trim, tw[9:7]);
        chk(supply_drop_trim, tw[5:3]);
    endtask
    // sel 0 pll start, 1 oscillator start, 2 erase with a refused restart
    task automatic meas(input int sel, output int len);
        int w;
        len = 0;
        w = 0;
        @(negedge clk);
        osc_start = (sel == 1);
        erase_start = (sel == 2);
        spd_pll_off = (sel != 0);
        @(negedge clk);
        osc_start = 1'b0;
        erase_start = 1'b0;
        while (((sel == 2) ? erase_busy : clk_suspend) !== 1'b1 && w < 4) begin
            @(negedge clk);
            w++;
        end
        while (((sel == 2) ? erase_busy : clk_suspend) === 1'b1 && len < 30000) begin
            erase_start = (sel == 2 && len == 100);
            @(negedge clk);
            len++;
        end
        erase_start = 1'b0;
        spd_pll_off = 1'b1;
    endtask
    initial begin
        seed = 32'h028e;
        {rst_n, por_n, osc_start, supply_low, wdt_clear, erase_start} = 6'h00;
        spd_pll_off = 1'b1;
        port_pins = 8'h00;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        por_n = 1'b1;
        @(negedge clk);
        check_decode(16'hffff, 16'hffff, 16'hffff);
        chk(dbg_allow, 1'b1);
        u_prog_model.rd(CFG + 32'h3f, rdat, rv);
        chk(rdat, 16'hffff);
        chk(rv, 1'b1);
        $display("test erased done");
        for (int i = 0; i < 6; i++) begin
            x = rnd();
            c = x[15:0];
            s = x[31:16] | 16'h8000;
            x = rnd();
            t = x[15:0];
            r = x[31:16];
            if (i == 0)
                s[6:4] = 3'h7;
            if (i == 1)
                s[14] = 1'b0;
            u_prog_model.wr(CFG + 32'h2, r);
            load(c, s, t);
            check_decode(c, s, t);
            u_prog_model.rd(CFG + 32'h2, rdat, rv);
            chk(rdat, r);
            x = rnd();
            p1 = x[7:0];
            supply_low = 1'b1;
            port_pins = p1;
            @(negedge clk);
            port_pins = x[15:8];
            #1;
            chk(brownout_reset, s[6:4] != 3'h7);
            chk(port_in_value, s[14] ? x[15:8] : p1);
            @(negedge clk);
            supply_low = 1'b0;
            u_prog_model.wr(CFG, ~c);
            chk(main_off, c[15]);
        end
        $display("test decode done");
        for (int k = 0; k < 8; k++) begin
            load({10'h000, k[2:0], 3'h0}, 16'hc070, 16'h0000);
            meas(0, n);
            chk(n >= pll_us[k] * TICK && n <= (pll_us[k] + 1) * TICK + 1, 1'b1);
        end
        for (int k = 0; k < 4; k++) begin
            load({13'h0000, k[2:0]}, 16'hc070, 16'h0000);
            meas(1, n);
            chk(n >= osc_us[k] * TICK && n <= (osc_us[k] + 1) * TICK + 1, 1'b1);
        end
        $display("test suspend done");
        for (int b = 0; b < 2; b++) begin
            load(16'h0000, 16'hc070, b ? 16'h0400 : 16'h0000);
            meas(2, n);
            chk(n >= (b ? 10000 : 20000) * TICK && n <= (b ? 10001 : 20001) * TICK + 1, 1'b1);
        end
        $display("test erase done");
        for (int ps = 0; ps < 8; ps++) begin
            load(16'h0000, 16'hc078 | ps[15:0], 16'h0000);
            wdt_clear = 1'b1;
            @(negedge clk);
            wdt_clear = 1'b0;
            n = 0;
            while (wdt_reset !== 1'b1 && n < 3000) begin
                @(negedge clk);
                n++;
            end
            chk(n >= (WDB << ps) - 1 && n <= (WDB << ps) + 1, 1'b1);
        end
        load(16'h0000, 16'hc078, 16'h0000);
        wd_cnt = 0;
        repeat (10) begin
            wdt_clear = 1'b1;
            @(negedge clk);
            wdt_clear = 1'b0;
            repeat (4) @(negedge clk);
        end
        chk(wd_cnt, 0);
        load(16'h0000, 16'hc070, 16'h0000);
        wd_cnt = 0;
        repeat (300) @(negedge clk);
        chk(wd_cnt, 0);
        $display("test watchdog done");
        u_prog_model.rd(32'h0000_0123, rdat, rv);
        chk(rdat, 16'h0123 ^ 16'h5a3c);
        u_prog_model.wr(32'h0002_0004, 16'h1234);
        u_prog_model.rd(CFG + 32'h4, rdat, rv);
        chk(rdat, 16'h0000);
        u_prog_model.wr(CFG + 32'h1, 16'h7fff);
        chk(protect_on, 1'b1);
        chk(dbg_allow, 1'b0);
        u_prog_model.rd(32'h0000_0123, rdat, rv);
        chk(rdat, 16'h0000);
        u_prog_model.wr(CFG + 32'h1, 16'hffff);
        reset_core();
        u_prog_model.rd(CFG + 32'h1, rdat, rv);
        chk(rdat, 16'h7fff);
        chk(rv, 1'b1);
        chk(protect_on, 1'b1);
        u_prog_model.protected_erase();
        reset_core();
        u_prog_model.rd(CFG + 32'h1, rdat, rv);
        chk(rdat, 16'hffff);
        chk(protect_on, 1'b0);
        chk(dbg_allow, 1'b1);
        $display("test protect done");
        stop_test();
    end
endmodule // tb
`default_nettype wire
